// file: verilog/ufilc_pkg.sv
/*
 * Constants for the serial port control block: register offsets, field
 * positions, reset values, trigger levels and time-out figures.
 * Assumes a 100 MHz system clock and an 8-bit plain register port.
 */
// Contract
// RL1: FIFOs on, enables clear: polled status only
// RL2: Data-ready reads 1 while receive FIFO nonempty
// RL3: Holding-empty and transmitter-empty track FIFO, shifter
// RL4: Mask bits 0-3 gate four interrupts; 4-7 zero
// RL5: Other FIFO bits ignored unless bit 0 set
// RL6: Clear bits flush FIFO, self-return to zero
// RL7: Bit 3 selects ready-pin mode 0 or 1
// RL8: Mode 0 tx ready low while transmit path empty; code drives it low on transmit FIFO count zero and ignores the shifter
// RL9: Mode 0 rx ready low while data present
// RL10: Mode 1 tx ready high only when full
// RL11: Mode 1 rx ready low at trigger/time-out
// RL12: Trigger codes give 1, 4, 8, 14
// RL13: Source register reports highest-priority pending interrupt
// RL14: Reading source clears only reported interrupt
// RL15: Source codes 1,6,4,C,2,0; bit0 low pending
// RL16: Bits 7:6 show FIFO enable; 5:4 zero
// RL17: Word length 5 to 8 bits
// RL18: Stop bits one, one-half or two
// RL19: Parity enable and odd/even select
// RL20: Stick parity forces constant parity bit
// RL21: Break holds serial output low
// RL22: Bit 7 switches addresses to divisor latch
// RL23: Modem bits drive active-low outputs inverted
// RL24: Divisor bytes reachable only with bit 7 set
// RL25: Receive interrupt follows count versus trigger
// RL26: Time-out after four idle character times
// RL27: Holding-register write clears transmit-empty interrupt
package ufilc_pkg;
    // =========================================================
    // Register offsets
    localparam logic [2:0] OFS_DATA   = 3'h0;
    localparam logic [2:0] OFS_MASK   = 3'h1;
    localparam logic [2:0] OFS_FIFO   = 3'h2;
    localparam logic [2:0] OFS_FORMAT = 3'h3;
    localparam logic [2:0] OFS_MODEM  = 3'h4;
    localparam logic [2:0] OFS_STATUS = 3'h5;
    localparam logic [2:0] OFS_SCRAT  = 3'h7;
    // =========================================================
    // Field positions
    localparam int FC_EN     = 0;
    localparam int FC_RXCLR  = 1;
    localparam int FC_TXCLR  = 2;
    localparam int FC_MODE   = 3;
    localparam int LF_STOP   = 2;
    localparam int LF_PAR    = 3;
    localparam int LF_EVEN   = 4;
    localparam int LF_STICK  = 5;
    localparam int LF_BREAK  = 6;
    localparam int LF_DIV    = 7;
    // =========================================================
    // Reset values and codes
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [3:0] SRC_NONE  = 4'h1;
    localparam logic [3:0] SRC_LINE  = 4'h6;
    localparam logic [3:0] SRC_RXD   = 4'h4;
    localparam logic [3:0] SRC_RXTO  = 4'hC;
    localparam logic [3:0] SRC_TXE   = 4'h2;
    localparam logic [3:0] SRC_MODEM = 4'h0;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;
    // =========================================================
    // Receive time-out: four character times, counted in sample ticks
    localparam int CHAR_TIMES   = 4;
    localparam int TICKS_PER_BIT = 16;
endpackage

// file: verilog/ufilc_top.sv
/*
 * Control and status section of a 16-byte FIFO serial transceiver:
 * interrupt masking and source reporting, FIFO control, ready pins,
 * line format and modem outputs.
 * Assumes the datapath supplies FIFO counts, shifter state, received
 * events and a 16x sample tick; the host uses a plain register port.
 */
module ufilc_top (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [7:0]      regRdata,
    input  wire logic [4:0] rxCount,
    input  wire logic [4:0] txCount,
    input  wire logic       txShiftBusy,
    input  wire logic       rxCharIn,
    input  wire logic       sampleTick,
    input  wire logic       lineErrEvt,
    input  wire logic       modemEvt,
    input  wire logic [4:0] lineErrBits,
    input  wire logic       txSerialRaw,
    output logic            txSerial,
    output logic            rxFifoPop,
    output logic            txFifoPush,
    output logic [7:0]      txData,
    output logic            rxFifoClear,
    output logic            txFifoClear,
    output logic            fifoEnabled,
    output logic [3:0]      dataBits,
    output logic [1:0]      stopHalfBits,
    output logic            parityOn,
    output logic            parityEven,
    output logic            parityStick,
    output logic [15:0]     divisor,
    output logic            tx_ready_pin_n,
    output logic            rx_ready_pin_n,
    output logic            termReady_n,
    output logic            sendRequest_n,
    output logic            user_output_one_n,
    output logic            user_output_two_n,
    output logic            irqLine
);
    // =========================================================
    // State
    typedef struct packed {
        logic [7:0]  maskR;
        logic [7:0]  fifoR;
        logic [7:0]  formatR;
        logic [7:0]  modemR;
        logic [7:0]  scratchR;
        logic [15:0] divR;
        logic        lineP;
        logic        modemP;
        logic        txeP;
        logic        toP;
        logic        rxRdyN;
        logic        txRdyN;
        logic [9:0]  idleCnt;
        logic [7:0]  rdata;
        logic        rxPop;
        logic        txPush;
        logic [7:0]  txByte;
        logic        rxClr;
        logic        txClr;
        logic        txOut;
        logic        irq;
        logic [4:0]  prevTx;
        logic [3:0]  wordLen;
        logic [1:0]  stopHalf;
        logic [3:0]  modemN;
    } ufilc_state_t;

    ufilc_state_t st_r;
    ufilc_state_t st_nxt;

    logic [4:0] trigLevel;
    logic       fifoOn;
    logic       rxTrig;
    logic [3:0] srcCode;
    logic [9:0] toLimit;
    logic       rdSrc;
    logic       wrHold;
    logic [7:0] statusByte;

    // =========================================================
    // Decode of trigger, time-out limit and current source
    always_comb begin
        fifoOn = st_r.fifoR[ufilc_pkg::FC_EN];
        case (st_r.fifoR[7:6]) // RL12
            2'h0:    trigLevel = ufilc_pkg::TRIG_L0;
            2'h1:    trigLevel = ufilc_pkg::TRIG_L1;
            2'h2:    trigLevel = ufilc_pkg::TRIG_L2;
            default: trigLevel = ufilc_pkg::TRIG_L3;
        endcase
        // Character frame is start + data + parity + stop, in ticks
        toLimit = 10'((ufilc_pkg::CHAR_TIMES * ufilc_pkg::TICKS_PER_BIT)
                  * (32'(st_r.formatR[1:0]) + 32'd8)); // RL26
        rxTrig = fifoOn ? (rxCount >= trigLevel)
                        : (rxCount != 5'h00); // RL25
        // Fixed priority: line, receive, time-out, transmit, modem
        if (st_r.maskR[2] && st_r.lineP)
            srcCode = ufilc_pkg::SRC_LINE; // RL13 RL15
        else if (st_r.maskR[0] && rxTrig)
            srcCode = ufilc_pkg::SRC_RXD;
        else if (st_r.maskR[0] && st_r.toP)
            srcCode = ufilc_pkg::SRC_RXTO;
        else if (st_r.maskR[1] && st_r.txeP)
            srcCode = ufilc_pkg::SRC_TXE;
        else if (st_r.maskR[3] && st_r.modemP)
            srcCode = ufilc_pkg::SRC_MODEM; // RL4
        else
            srcCode = ufilc_pkg::SRC_NONE; // RL1
        rdSrc  = regRd && regAddr == ufilc_pkg::OFS_FIFO;
        wrHold = regWr && regAddr == ufilc_pkg::OFS_DATA
                 && !st_r.formatR[ufilc_pkg::LF_DIV];
        statusByte = {1'b0,
                      txCount == 5'h00 && !txShiftBusy, // RL3
                      txCount == 5'h00,
                      lineErrBits[4:1],
                      rxCount != 5'h00}; // RL2
    end

    // =========================================================
    // Next-state logic; hardware sets beat clears throughout
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rxPop  = 1'b0;
        st_nxt.txPush = 1'b0;
        st_nxt.rxClr  = 1'b0;
        st_nxt.txClr  = 1'b0;
        st_nxt.prevTx = txCount;
        // Register writes
        if (regWr) begin
            case (regAddr)
                ufilc_pkg::OFS_DATA: begin
                    if (st_r.formatR[ufilc_pkg::LF_DIV])
                        st_nxt.divR[7:0] = regWdata; // RL22 RL24
                    else begin
                        st_nxt.txPush = 1'b1;
                        st_nxt.txByte = regWdata;
                    end
                end
                ufilc_pkg::OFS_MASK: begin
                    if (st_r.formatR[ufilc_pkg::LF_DIV])
                        st_nxt.divR[15:8] = regWdata; // RL24
                    else
                        st_nxt.maskR = {4'h0, regWdata[3:0]}; // RL4
                end
                ufilc_pkg::OFS_FIFO: begin
                    if (regWdata[ufilc_pkg::FC_EN])
                        st_nxt.fifoR = {regWdata[7:6], 2'b00,
                                        regWdata[3], 3'b001}; // RL5 RL7
                    else
                        st_nxt.fifoR = ufilc_pkg::RST_ZERO; // RL5
                    // Clear bits act once and never stay stored
                    st_nxt.rxClr = regWdata[ufilc_pkg::FC_EN]
                                   & regWdata[ufilc_pkg::FC_RXCLR]; // RL6
                    st_nxt.txClr = regWdata[ufilc_pkg::FC_EN]
                                   & regWdata[ufilc_pkg::FC_TXCLR]; // RL6
                end
                ufilc_pkg::OFS_FORMAT: st_nxt.formatR = regWdata;
                ufilc_pkg::OFS_MODEM:  st_nxt.modemR = {3'h0, regWdata[4:0]};
                ufilc_pkg::OFS_SCRAT:  st_nxt.scratchR = regWdata;
                default: ;
            endcase
        end
        // Reading the source register drops only what it reported
        if (rdSrc) begin
            case (srcCode) // RL14
                ufilc_pkg::SRC_LINE:  st_nxt.lineP = 1'b0;
                ufilc_pkg::SRC_RXTO:  st_nxt.toP = 1'b0;
                ufilc_pkg::SRC_TXE:   st_nxt.txeP = 1'b0;
                ufilc_pkg::SRC_MODEM: st_nxt.modemP = 1'b0;
                default: ;
            endcase
        end
        if (wrHold)
            st_nxt.txeP = 1'b0; // RL27
        if (regRd && regAddr == ufilc_pkg::OFS_STATUS)
            st_nxt.lineP = 1'b0;
        // Event sets come last so they win
        if (lineErrEvt)
            st_nxt.lineP = 1'b1;
        if (modemEvt)
            st_nxt.modemP = 1'b1;
        if (txCount == 5'h00 && st_r.prevTx != 5'h00)
            st_nxt.txeP = 1'b1;
        // Time-out counter: idle time with data below the trigger
        if (rxCharIn || (regRd && regAddr == ufilc_pkg::OFS_DATA)
            || rxCount == 5'h00 || rxTrig) begin
            st_nxt.idleCnt = 10'h000;
            if (rxCount == 5'h00)
                st_nxt.toP = 1'b0;
        end else if (sampleTick) begin
            if (st_r.idleCnt >= toLimit)
                st_nxt.toP = 1'b1; // RL26
            else
                st_nxt.idleCnt = st_r.idleCnt + 10'h001;
        end
        // Ready pins
        if (!fifoOn || !st_r.fifoR[ufilc_pkg::FC_MODE]) begin
            st_nxt.txRdyN = txCount != 5'h00; // RL8
            st_nxt.rxRdyN = rxCount == 5'h00; // RL9
        end else begin
            st_nxt.txRdyN = txCount == ufilc_pkg::FIFO_DEPTH; // RL10
            if (rxTrig || st_r.toP)
                st_nxt.rxRdyN = 1'b0; // RL11
            else if (rxCount == 5'h00)
                st_nxt.rxRdyN = 1'b1; // RL11
        end
        st_nxt.txOut = st_r.formatR[ufilc_pkg::LF_BREAK]
                       ? 1'b0 : txSerialRaw; // RL21
        st_nxt.irq = srcCode[0] == 1'b0;
        // Decoded format and pin levels are registered so every output
        // leaves a flip-flop; they follow the value written this cycle
        st_nxt.wordLen  = 4'(st_nxt.formatR[1:0]) + 4'h5; // RL17
        // Half-bit units: 2 = one, 3 = one and a half, 0 = two (4 halves)
        st_nxt.stopHalf = !st_nxt.formatR[ufilc_pkg::LF_STOP] ? 2'h2 // RL18
                          : (st_nxt.formatR[1:0] == 2'h0 ? 2'h3 : 2'h0);
        st_nxt.modemN   = ~st_nxt.modemR[3:0]; // RL23
        // Read data, one cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (regRd) begin
            case (regAddr)
                ufilc_pkg::OFS_DATA: begin
                    if (st_r.formatR[ufilc_pkg::LF_DIV])
                        st_nxt.rdata = st_r.divR[7:0];
                    else
                        st_nxt.rxPop = 1'b1;
                end
                ufilc_pkg::OFS_MASK:
                    st_nxt.rdata = st_r.formatR[ufilc_pkg::LF_DIV]
                                   ? st_r.divR[15:8] : st_r.maskR;
                ufilc_pkg::OFS_FIFO:
                    st_nxt.rdata = {fifoOn, fifoOn, 2'b00, srcCode}; // RL16
                ufilc_pkg::OFS_FORMAT: st_nxt.rdata = st_r.formatR;
                ufilc_pkg::OFS_MODEM:  st_nxt.rdata = st_r.modemR;
                ufilc_pkg::OFS_STATUS: st_nxt.rdata = statusByte;
                ufilc_pkg::OFS_SCRAT:  st_nxt.rdata = st_r.scratchR;
                default:               st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r        <= '0;
            st_r.rxRdyN <= 1'b1;
            st_r.txRdyN <= 1'b0;
            st_r.txOut  <= 1'b1;
            st_r.wordLen  <= 4'h5;
            st_r.stopHalf <= 2'h2;
            st_r.modemN   <= 4'hF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // Outputs, all straight from flip-flops
    assign regRdata          = st_r.rdata;
    assign rxFifoPop         = st_r.rxPop;
    assign txFifoPush        = st_r.txPush;
    assign txData            = st_r.txByte;
    assign rxFifoClear       = st_r.rxClr;
    assign txFifoClear       = st_r.txClr;
    assign fifoEnabled       = st_r.fifoR[ufilc_pkg::FC_EN];
    assign dataBits          = st_r.wordLen; // RL17
    assign stopHalfBits      = st_r.stopHalf; // RL18
    assign parityOn          = st_r.formatR[ufilc_pkg::LF_PAR]; // RL19
    assign parityEven        = st_r.formatR[ufilc_pkg::LF_EVEN];
    assign parityStick       = st_r.formatR[ufilc_pkg::LF_STICK]; // RL20
    assign divisor           = st_r.divR;
    assign tx_ready_pin_n    = st_r.txRdyN;
    assign rx_ready_pin_n    = st_r.rxRdyN;
    assign termReady_n       = st_r.modemN[0]; // RL23
    assign sendRequest_n     = st_r.modemN[1];
    assign user_output_one_n = st_r.modemN[2];
    assign user_output_two_n = st_r.modemN[3];
    assign txSerial          = st_r.txOut;
    assign irqLine           = st_r.irq;

    // =========================================================
    // Checks
    chk_break_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_r.formatR[6] |=> txSerial == 1'b0) // RL21
        else $error("break not driving line low");
    chk_mask_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_r.maskR[7:4] == 4'h0) // RL4
        else $error("mask upper bits set");
    chk_clear_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        rxFifoClear |=> !rxFifoClear) // RL6
        else $error("receive clear held");
    chk_src_fifo: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdSrc |=> regRdata[7:6] == {2{$past(fifoOn)}}) // RL16
        else $error("source bits 7:6 wrong");
    chk_modem_out: assert property (@(posedge ref_clk) disable iff (!rstn)
        termReady_n == !st_r.modemR[0]) // RL23
        else $error("terminal ready polarity wrong");
    chk_txe_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrHold && !(txCount == 5'h00 && st_r.prevTx != 5'h00)
        |=> !st_r.txeP) // RL27
        else $error("hold write left transmit interrupt");
    chk_fifo_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWr && regAddr == 3'h2 && !regWdata[0] |=> !fifoEnabled) // RL5
        else $error("fifo enabled without bit 0");
    chk_poll_none: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_r.maskR[3:0] == 4'h0 |=> !irqLine) // RL1
        else $error("interrupt with all masked");
endmodule

// file: tb/ufilc_dpath_model.sv
/*
 * Datapath stand-in: fill counters of the receive and transmit FIFOs.
 * Assumes the bench commands arrivals and drains with level pulses.
 */
module ufilc_dpath_model (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       rxFifoPop,
    input  wire logic       txFifoPush,
    input  wire logic       rxFifoClear,
    input  wire logic       txFifoClear,
    input  wire logic       addRx,
    input  wire logic       drainTx,
    output logic [4:0]      rxCount,
    output logic [4:0]      txCount,
    output logic            rxCharIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Counters
    // Saturate at 16 and 0: a real FIFO drops overruns, never wraps
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxCount  <= 5'h00;
            txCount  <= 5'h00;
            rxCharIn <= 1'b0;
        end else begin
            rxCharIn <= addRx && rxCount < 5'h10;
            if (rxFifoClear) begin
                rxCount <= 5'h00;
            end else if (addRx && rxCount < 5'h10) begin
                rxCount <= rxCount + 5'h01;
            end else if (rxFifoPop && rxCount != 5'h00) begin
                rxCount <= rxCount - 5'h01;
            end
            if (txFifoClear) begin
                txCount <= 5'h00;
            end else if (txFifoPush && txCount < 5'h10) begin
                txCount <= txCount + 5'h01;
            end else if (drainTx && txCount != 5'h00) begin
                txCount <= txCount - 5'h01;
            end
        end
    end
endmodule

// file: tb/tb_top.sv
/*
 * Bench for the serial port control block: register port tasks and
 * access sequences with expected values.
 * Assumes the package constants and the datapath stand-in model.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rstn, regWr, regRd, addRx, drainTx;
    logic [2:0]  regAddr;
    logic [7:0]  regWdata, regRdata, txData, v;
    logic [4:0]  rxCount, txCount;
    logic        txShiftBusy, rxCharIn, lineErrEvt, modemEvt;
    logic        sampleTick = 1'b0;
    logic        txSerialRaw, txSerial, rxFifoPop, txFifoPush;
    logic        rxFifoClear, txFifoClear, fifoEnabled, parityOn;
    logic        parityEven, parityStick, tx_ready_pin_n;
    logic        rx_ready_pin_n, termReady_n, sendRequest_n;
    logic        user_output_one_n, user_output_two_n, irqLine;
    logic [3:0]  dataBits;
    logic [1:0]  stopHalfBits;
    logic [15:0] divisor;
    int          failCount = 0;
    int          nTests = 0;
    int          lvl [4] = '{1, 4, 8, 14};

    ufilc_top dut (
        .ref_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .rxCount, .txCount, .txShiftBusy, .rxCharIn, .sampleTick,
        .lineErrEvt, .modemEvt, .lineErrBits(5'h00), .txSerialRaw,
        .txSerial, .rxFifoPop, .txFifoPush, .txData, .rxFifoClear,
        .txFifoClear, .fifoEnabled, .dataBits, .stopHalfBits, .parityOn,
        .parityEven, .parityStick, .divisor, .tx_ready_pin_n,
        .rx_ready_pin_n, .termReady_n, .sendRequest_n,
        .user_output_one_n, .user_output_two_n, .irqLine
    );
    ufilc_dpath_model model (
        .ref_clk, .rstn, .rxFifoPop, .txFifoPush, .rxFifoClear,
        .txFifoClear, .addRx, .drainTx, .rxCount, .txCount, .rxCharIn
    );
    // ==========================================================
    // Clock and sample tick (every other cycle keeps time-out short)
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) sampleTick <= ~sampleTick;
    // ==========================================================
    // Compare, access and stimulus tasks
    task automatic chkPin(input string n, input logic [15:0] e, g);
        nTests++;
        if (g !== e) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr    <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic rdChk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chkPin($sformatf("reg %0d", a), {8'h00, e}, {8'h00, d});
    endtask
    task automatic srcChk(input logic [7:0] e);
        rdChk(ufilc_pkg::OFS_FIFO, e);
    endtask
    task automatic rdyChk(input logic [1:0] e);
        tick(3);
        chkPin("ready", {14'h0, e}, {14'h0, tx_ready_pin_n, rx_ready_pin_n});
    endtask
    task automatic irqChk(input logic e);
        tick(3);
        chkPin("irq", {15'h0, e}, {15'h0, irqLine});
    endtask
    // Holding the command high for n edges moves n characters
    task automatic rxIn(input int n);
        @(posedge ref_clk);
        addRx <= 1'b1;
        repeat (n) @(posedge ref_clk);
        addRx <= 1'b0;
        #1;
    endtask
    task automatic txOut(input int n);
        @(posedge ref_clk);
        drainTx <= 1'b1;
        repeat (n) @(posedge ref_clk);
        drainTx <= 1'b0;
        #1;
    endtask
    task automatic events();
        @(posedge ref_clk);
        lineErrEvt <= 1'b1;
        modemEvt   <= 1'b1;
        @(posedge ref_clk);
        lineErrEvt <= 1'b0;
        modemEvt   <= 1'b0;
    endtask
    task automatic doReset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
    endtask
    task automatic closeOut();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog: the sequence needs some 1500 cycles, allow about thirteen times
    initial begin
        #200000;
        failCount++;
        closeOut();
    end
    // ==========================================================
    // Test sequence
    initial begin
        {rstn, regWr, regRd, addRx, drainTx, lineErrEvt, modemEvt} = '0;
        {regAddr, regWdata, txShiftBusy} = '0;
        txSerialRaw = 1'b1;
        doReset();
        chkPin("pins", 16'h007D, {8'h00, tx_ready_pin_n, rx_ready_pin_n,
            termReady_n, sendRequest_n, user_output_one_n,
            user_output_two_n, irqLine, txSerial});
        rdChk(ufilc_pkg::OFS_MASK, 8'h00);
        srcChk(8'h01);
        rdChk(ufilc_pkg::OFS_FORMAT, 8'h00);
        rdChk(ufilc_pkg::OFS_STATUS, 8'h60);
        rdChk(3'h6, 8'h00);
        wr(ufilc_pkg::OFS_MASK, 8'hFF);
        rdChk(ufilc_pkg::OFS_MASK, 8'h0F);
        wr(ufilc_pkg::OFS_MASK, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(ufilc_pkg::OFS_MODEM, 8'(i));
            chkPin("modem", {12'h000, ~4'(i)}, {12'h000, user_output_two_n,
                user_output_one_n, sendRequest_n, termReady_n});
        end
        rdChk(ufilc_pkg::OFS_MODEM, 8'h0F);
        for (int i = 0; i < 64; i++) begin
            wr(ufilc_pkg::OFS_FORMAT, 8'(i));
            chkPin("bits", 16'(5 + i % 4), {12'h000, dataBits});
            chkPin("stop", 16'(!i[2] ? 2 : (i % 4 == 0 ? 3 : 0)),
                {14'h0, stopHalfBits});
            chkPin("parity", 16'(i >> 3),
                {13'h0, parityStick, parityEven, parityOn});
        end
        rdChk(ufilc_pkg::OFS_FORMAT, 8'h3F);
        wr(ufilc_pkg::OFS_FORMAT, 8'h40);
        irqChk(1'b0);
        chkPin("break", 16'h0000, {15'h0, txSerial});
        wr(ufilc_pkg::OFS_FORMAT, 8'h80);
        wr(ufilc_pkg::OFS_DATA, 8'h34);
        wr(ufilc_pkg::OFS_MASK, 8'h12);
        chkPin("divisor", 16'h1234, divisor);
        rdChk(ufilc_pkg::OFS_MASK, 8'h12);
        wr(ufilc_pkg::OFS_FORMAT, 8'h00);
        wr(ufilc_pkg::OFS_MASK, 8'h05);
        tick(2);
        chkPin("line", 16'h0001, {15'h0, txSerial});
        chkPin("divisor", 16'h1234, divisor);
        chkPin("txCount", 16'h0000, {11'h0, txCount});
        rdChk(ufilc_pkg::OFS_MASK, 8'h05);
        wr(ufilc_pkg::OFS_MASK, 8'h00);
        wr(ufilc_pkg::OFS_FIFO, 8'hCE);
        chkPin("fifoOn", 16'h0000, {15'h0, fifoEnabled});
        srcChk(8'h01);
        wr(ufilc_pkg::OFS_FIFO, 8'h01);
        srcChk(8'hC1);
        rxIn(5);
        wr(ufilc_pkg::OFS_DATA, 8'hA5);
        chkPin("txData", 16'h00A5, {8'h00, txData});
        wr(ufilc_pkg::OFS_FIFO, 8'h07);
        tick(3);
        chkPin("counts", 16'h0000, {6'h00, rxCount, txCount});
        rxIn(2);
        wr(ufilc_pkg::OFS_FIFO, 8'h01);
        tick(3);
        chkPin("rxCount", 16'h0002, {11'h0, rxCount});
        rdyChk(2'b00);
        rdChk(ufilc_pkg::OFS_STATUS, 8'h61);
        rd(ufilc_pkg::OFS_DATA, v);
        rd(ufilc_pkg::OFS_DATA, v);
        wr(ufilc_pkg::OFS_DATA, 8'h3C);
        rdyChk(2'b11);
        rdChk(ufilc_pkg::OFS_STATUS, 8'h00);
        txShiftBusy <= 1'b1;
        txOut(1);
        rdyChk(2'b01);
        rdChk(ufilc_pkg::OFS_STATUS, 8'h20);
        txShiftBusy <= 1'b0;
        wr(ufilc_pkg::OFS_FIFO, 8'h49);
        for (int i = 0; i < 15; i++) wr(ufilc_pkg::OFS_DATA, 8'(i));
        rdyChk(2'b01);
        wr(ufilc_pkg::OFS_DATA, 8'h0F);
        rdyChk(2'b11);
        txOut(16);
        rxIn(3);
        rdyChk(2'b01);
        rxIn(1);
        rdyChk(2'b00);
        for (int i = 0; i < 3; i++) rd(ufilc_pkg::OFS_DATA, v);
        rdyChk(2'b00);
        rd(ufilc_pkg::OFS_DATA, v);
        rdyChk(2'b01);
        wr(ufilc_pkg::OFS_MASK, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(ufilc_pkg::OFS_FIFO, {2'(k), 6'h03});
            if (lvl[k] > 1) rxIn(lvl[k] - 1);
            irqChk(1'b0);
            rxIn(1);
            irqChk(1'b1);
            srcChk(8'hC4);
            rd(ufilc_pkg::OFS_DATA, v);
            irqChk(1'b0);
        end
        doReset();
        wr(ufilc_pkg::OFS_FIFO, 8'h01);
        events();
        rxIn(1);
        irqChk(1'b0);
        rd(ufilc_pkg::OFS_DATA, v);
        wr(ufilc_pkg::OFS_MASK, 8'h0F);
        wr(ufilc_pkg::OFS_DATA, 8'h55);
        txOut(1);
        events();
        rxIn(1);
        irqChk(1'b1);
        srcChk(8'hC6);
        srcChk(8'hC4);
        srcChk(8'hC4);
        rd(ufilc_pkg::OFS_DATA, v);
        srcChk(8'hC2);
        srcChk(8'hC0);
        srcChk(8'hC1);
        irqChk(1'b0);
        wr(ufilc_pkg::OFS_DATA, 8'h66);
        txOut(1);
        wr(ufilc_pkg::OFS_DATA, 8'h77);
        srcChk(8'hC1);
        wr(ufilc_pkg::OFS_FIFO, 8'h4F);
        wr(ufilc_pkg::OFS_MASK, 8'h01);
        rxIn(1);
        for (int w = 0; w < 5000 && irqLine !== 1'b1; w++) tick(1);
        srcChk(8'hCC);
        rdyChk(2'b00);
        closeOut();
    end
endmodule
